//--- monitor_offset_config_mask_regs.v
// What this block does
// RQ1: Add local offset to local results
// RQ2: Add remote-two offset to remote-two results
// RQ3: Lock makes both offsets ignore writes
// RQ4: Sense bit selects three- or two-wire fan
// RQ5: Two-wire sense only in low frequency
// RQ6: Averaging-disable bit stops conversion averaging
// RQ7: Attenuator-bypass bit removes core rail attenuator
// RQ8: Single-channel bit converts one selected input
// RQ9: Selector decodes five channels, three reserved
// RQ10: Power-down drives PWM outputs inactive
// RQ11: Duty readback is zero while powered down
// RQ12: Mask bits 4-6 gate temperature alerts
// RQ13: Mask bits 1-2 gate rail alerts
// RQ14: Mask bit 7 gates status-two alerts
// RQ15: Masks gate alert only, not status
// RQ16: Registers reset zero; reserved codes inert
//
// Register slice: two temperature offsets, configuration two, mask one.
// Assumes an SMBus engine on clk_i turns transactions into the register
// port below, and that all other inputs come from logic on clk_i.
`include "monitor_regs_map.vh"

module monitor_offset_config_mask_regs (
  input wire clk_i,                      // Device clock, 20 MHz
  input wire rstn_i,                     // Sync reset, active low
  // Register port from the SMBus engine
  input wire [7:0] reg_addr_i,           // Register pointer
  input wire [7:0] reg_wdata_i,          // Write data
  input wire reg_wr_i,                   // Write strobe
  input wire reg_rd_i,                   // Read strobe
  output reg [7:0] reg_rdata_o,          // Read data
  output reg reg_rvalid_o,               // Read data strobe
  output reg reg_hit_o,                  // Access hit this slice
  output reg wr_refused_o,               // Write dropped by lock
  // Device context
  input wire lock_i,                     // Write-protect from config one
  input wire low_freq_mode_i,            // Fan drive in low frequency
  input wire [7:0] sense_thresh_i,       // Threshold from config four
  input wire [2:0] chan_sel_i,           // Selector bits from speed_pulse_input min high
  input wire pwm_polarity_flip_i,        // PWM polarity flip
  // Temperature results
  input wire [`TEMP_W-1:0] local_raw_i,  // Raw local result
  input wire local_raw_valid_i,          // Raw local strobe
  input wire [`TEMP_W-1:0] remote2_raw_i, // Raw remote-two result
  input wire remote2_raw_valid_i,        // Raw remote-two strobe
  output wire [`TEMP_W-1:0] local_temp_o, // Corrected local result
  output wire local_temp_valid_o,        // Corrected local strobe
  output wire [`TEMP_W-1:0] remote2_temp_o, // Corrected remote-two
  output wire remote2_temp_valid_o,      // Corrected remote-two strobe
  // Fan sensing
  output reg [3:0] two_wire_sense_o,     // Per pin two-wire sensing
  output reg [7:0] sense_thresh_o,       // Two-wire sense threshold
  // Converter control
  output reg averaging_disable_o,        // Averaging off
  output reg attenuator_bypass_o,        // Core rail attenuator out
  output reg single_channel_mode_o,      // Convert one input only
  output reg [4:0] single_channel_mode_chan_o,          // One-hot selected input
  // PWM and duty readback
  input wire [2:0] pwm_raw_i,            // PWM from the generator
  output reg [2:0] pwm_o,                // PWM to the pins
  input wire [23:0] cur_duty_i,          // Live duty, three bytes
  output reg [23:0] cur_duty_o,          // Duty as read back
  output reg power_down_o,               // Shutdown active
  // Alert
  input wire [7:0] status_one_i,         // Status one out-of-limit bits
  input wire status_two_any_i,           // Any status two bit set
  output reg alert_pending_o,            // Unmasked event present
  output wire alert_out_o,               // Open-drain alert, level
  output wire alert_oe_o                 // Alert enable, low drives
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] local_temp_offset;
  reg [7:0] remote_two_temp_offset;
  reg [7:0] monitor_config_two;
  reg [7:0] alert_mask_one;
  reg [7:0] next_local_temp_offset;
  reg [7:0] next_remote_two_temp_offset;
  reg [7:0] next_monitor_config_two;
  reg [7:0] next_alert_mask_one;
  reg [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, one bit per register; shared by writes, hits and reads
  function [3:0] reg_slot;
    input [7:0] addr;
    begin
      case (addr)
        `ADDR_LOCAL_OFS:
          reg_slot = 4'h1;
        `ADDR_REMOTE2_OFS:
          reg_slot = 4'h2;
        `ADDR_CONFIG_TWO:
          reg_slot = 4'h4;
        `ADDR_MASK_ONE:
          reg_slot = 4'h8;
        default:
          reg_slot = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] slot;
  wire hit_local;
  wire hit_remote2;
  wire hit_config;
  wire hit_mask;
  wire hit_any;
  wire ofs_write;

  assign slot = reg_slot(reg_addr_i);
  assign hit_local = slot[0];
  assign hit_remote2 = slot[1];
  assign hit_config = slot[2];
  assign hit_mask = slot[3];
  assign hit_any = hit_local | hit_remote2 | hit_config | hit_mask;
  assign ofs_write = reg_wr_i & (hit_local | hit_remote2);

  ////////////////////////////////////////////////////////////////////////////
  // Writes
  always @*
  begin
    next_local_temp_offset = local_temp_offset;
    next_remote_two_temp_offset = remote_two_temp_offset;
    next_monitor_config_two = monitor_config_two;
    next_alert_mask_one = alert_mask_one;
    // Lock is sampled at the write edge, so a write in the
    // same cycle that lock rises is already refused
    if (reg_wr_i && !lock_i)
    begin
      if (hit_local)
        next_local_temp_offset = reg_wdata_i; // RQ3
      if (hit_remote2)
        next_remote_two_temp_offset = reg_wdata_i; // RQ3
    end
    if (reg_wr_i && hit_config)
      next_monitor_config_two = reg_wdata_i;
    if (reg_wr_i && hit_mask)
      next_alert_mask_one = reg_wdata_i;
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      local_temp_offset <= `RST_LOCAL_OFS; // RQ16
      remote_two_temp_offset <= `RST_REMOTE2_OFS; // RQ16
      monitor_config_two <= `RST_CONFIG_TWO; // RQ16
      alert_mask_one <= `RST_MASK_ONE; // RQ16
      wr_refused_o <= 1'b0;
    end
    else
    begin
      wr_refused_o <= ofs_write & lock_i; // RQ3
      local_temp_offset <= next_local_temp_offset;
      remote_two_temp_offset <= next_remote_two_temp_offset;
      monitor_config_two <= next_monitor_config_two;
      alert_mask_one <= next_alert_mask_one;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads: one cycle after the strobe, unmapped reads return zero
  always @*
  begin
    case (slot)
      4'h1:
        next_rdata = local_temp_offset;
      4'h2:
        next_rdata = remote_two_temp_offset;
      4'h4:
        next_rdata = monitor_config_two;
      4'h8:
        next_rdata = alert_mask_one;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
      reg_hit_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      reg_hit_o <= (reg_rd_i | reg_wr_i) & hit_any;
      if (reg_rd_i)
        reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset correction of temperature results
  temp_offset_adder u_local_adder (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .raw_i(local_raw_i),
    .raw_valid_i(local_raw_valid_i),
    .offset_i(local_temp_offset), // RQ1
    .result_o(local_temp_o),
    .result_valid_o(local_temp_valid_o)
  );

  temp_offset_adder u_remote2_adder (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .raw_i(remote2_raw_i),
    .raw_valid_i(remote2_raw_valid_i),
    .offset_i(remote_two_temp_offset), // RQ2
    .result_o(remote2_temp_o),
    .result_valid_o(remote2_temp_valid_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Single-channel selector decode
  function [4:0] decode_chan;
    input [2:0] sel;
    begin
      case (sel)
        `SEL_CORE:
          decode_chan = 5'h01;
        `SEL_SUPPLY:
          decode_chan = 5'h02;
        `SEL_REMOTE1:
          decode_chan = 5'h04;
        `SEL_LOCAL:
          decode_chan = 5'h08;
        `SEL_REMOTE2:
          decode_chan = 5'h10;
        default:
          decode_chan = 5'h00;
      endcase
    end
  endfunction

  wire [4:0] chan_onehot;
  wire single_req;

  assign chan_onehot = decode_chan(chan_sel_i); // RQ9
  // Reserved code leaves the converter scanning as normal
  assign single_req = monitor_config_two[`CFG_SINGLE] & (|chan_onehot); // RQ16

  ////////////////////////////////////////////////////////////////////////////
  // Fan sense controls
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      two_wire_sense_o <= 4'h0;
      sense_thresh_o <= 8'h00;
    end
    else
    begin
      // Two-wire sensing needs the slow drive to see the dips
      two_wire_sense_o <= monitor_config_two[`CFG_SENSE_HI:`CFG_SENSE_LO]
        & {4{low_freq_mode_i}}; // RQ4 RQ5
      sense_thresh_o <= sense_thresh_i; // RQ5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter controls
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      averaging_disable_o <= 1'b0;
      attenuator_bypass_o <= 1'b0;
      single_channel_mode_o <= 1'b0;
      single_channel_mode_chan_o <= 5'h00;
    end
    else
    begin
      averaging_disable_o <= monitor_config_two[`CFG_AVG_OFF]; // RQ6
      attenuator_bypass_o <= monitor_config_two[`CFG_ATTENUATOR_BYPASS_BYP]; // RQ7
      single_channel_mode_o <= single_req; // RQ8
      single_channel_mode_chan_o <= single_req ? chan_onehot : 5'h00; // RQ8
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down of the fan drive
  wire pwr_down;

  assign pwr_down = monitor_config_two[`CFG_PWR_DOWN];

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pwm_o <= 3'h0;
      cur_duty_o <= 24'h000000;
      power_down_o <= 1'b0;
    end
    else
    begin
      power_down_o <= pwr_down;
      if (pwr_down)
      begin
        pwm_o <= {3{pwm_polarity_flip_i}}; // RQ10
        cur_duty_o <= {3{`DUTY_OFF}}; // RQ11
      end
      else
      begin
        pwm_o <= pwm_raw_i;
        cur_duty_o <= cur_duty_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert gating; status bits stay with their owners, only the pin is masked
  wire remote_one_alert;
  wire local_alert;
  wire remote_two_alert;
  wire core_rail_alert;
  wire supply_rail_alert;
  wire status_two_alert;

  // Only defined positions are read, so mask bits 0 and 3 gate nothing
  assign remote_one_alert = status_one_i[`MSK_REMOTE1]
    & ~alert_mask_one[`MSK_REMOTE1]; // RQ12
  assign local_alert = status_one_i[`MSK_LOCAL]
    & ~alert_mask_one[`MSK_LOCAL]; // RQ12
  assign remote_two_alert = status_one_i[`MSK_REMOTE2]
    & ~alert_mask_one[`MSK_REMOTE2]; // RQ12
  assign core_rail_alert = status_one_i[`MSK_CORE]
    & ~alert_mask_one[`MSK_CORE]; // RQ13
  assign supply_rail_alert = status_one_i[`MSK_SUPPLY]
    & ~alert_mask_one[`MSK_SUPPLY]; // RQ13
  assign status_two_alert = status_two_any_i & ~alert_mask_one[`MSK_STATUS2]; // RQ14

  always @(posedge clk_i)
  begin
    if (!rstn_i)
      alert_pending_o <= 1'b0;
    else
      alert_pending_o <= remote_one_alert | local_alert | remote_two_alert
        | core_rail_alert | supply_rail_alert
        | status_two_alert; // RQ15 RQ16
  end

  // Open drain: pull low while an event is pending, else release
  assign alert_out_o = 1'b0;
  assign alert_oe_o = ~alert_pending_o; // RQ15

endmodule

//--- monitor_regs_map.vh
// Offsets, field positions and constants for the offset, config and mask slice.
// Assumes it is included by bare name from the design files of this block.
`ifndef MONITOR_REGS_MAP_VH
`define MONITOR_REGS_MAP_VH

// Register offsets
`define ADDR_LOCAL_OFS 8'h71
`define ADDR_REMOTE2_OFS 8'h72
`define ADDR_CONFIG_TWO 8'h73
`define ADDR_MASK_ONE 8'h74

// Reset values
`define RST_LOCAL_OFS 8'h00
`define RST_REMOTE2_OFS 8'h00
`define RST_CONFIG_TWO 8'h00
`define RST_MASK_ONE 8'h00

// Configuration two fields
`define CFG_SENSE_LO 0
`define CFG_SENSE_HI 3
`define CFG_AVG_OFF 4
`define CFG_ATTENUATOR_BYPASS_BYP 5
`define CFG_SINGLE 6
`define CFG_PWR_DOWN 7

// Mask one fields
`define MSK_CORE 1
`define MSK_SUPPLY 2
`define MSK_REMOTE1 4
`define MSK_LOCAL 5
`define MSK_REMOTE2 6
`define MSK_STATUS2 7
`define MSK_DEFINED 8'hF6

// Single-channel selector codes
`define SEL_CORE 3'h1
`define SEL_SUPPLY 3'h2
`define SEL_REMOTE1 3'h5
`define SEL_LOCAL 3'h6
`define SEL_REMOTE2 3'h7

// Temperature results: quarter degree per count
`define TEMP_W 10
`define TEMP_MAX 12'h3FF
`define OFS_SHIFT 1
`define DUTY_OFF 8'h00

`endif

//--- temp_offset_adder.v
// Adds a signed half-degree offset to a quarter-degree temperature result.
// Assumes raw results arrive on clk_i with a one-cycle valid strobe.
`include "monitor_regs_map.vh"

module temp_offset_adder (
  input wire clk_i,                      // Device clock
  input wire rstn_i,                     // Sync reset, active low
  input wire [`TEMP_W-1:0] raw_i,        // Raw result
  input wire raw_valid_i,                // Raw result strobe
  input wire [7:0] offset_i,             // Signed offset, 0.5 C per count
  output reg [`TEMP_W-1:0] result_o,     // Corrected result
  output reg result_valid_o              // Corrected result strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // Saturating add; clamps rather than wrapping past the scale ends
  function [`TEMP_W-1:0] sat_add;
    input [`TEMP_W-1:0] raw;
    input [7:0] ofs;
    reg signed [11:0] sum;
    begin
      sum = $signed({2'b00, raw}) + ($signed({{4{ofs[7]}}, ofs}) <<< `OFS_SHIFT);
      if (sum < 12'sd0)
        sat_add = {`TEMP_W{1'b0}};
      else if (sum > $signed(`TEMP_MAX))
        sat_add = {`TEMP_W{1'b1}};
      else
        sat_add = sum[`TEMP_W-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      result_o <= {`TEMP_W{1'b0}};
      result_valid_o <= 1'b0;
    end
    else
    begin
      result_valid_o <= raw_valid_i;
      if (raw_valid_i)
        result_o <= sat_add(raw_i, offset_i);
    end
  end

endmodule

//--- monitor_regs_props.sv
// Checker for the offset, config and mask slice, bound to its top.
// Assumes one clock domain and the port names of that top module.
module monitor_regs_props (
  input wire clk_i, // Clock
  input wire rstn_i, // Reset, low
  input wire [7:0] reg_addr_i, // Pointer
  input wire reg_wr_i, // Write strobe
  input wire wr_refused_o, // Refused
  input wire lock_i, // Lock
  input wire low_freq_mode_i, // Low freq
  input wire [2:0] chan_sel_i, // Selector
  input wire pwm_polarity_flip_i, // Flip
  input wire local_raw_valid_i, // Raw strobe
  input wire local_temp_valid_o, // Result strobe
  input wire [3:0] two_wire_sense_o, // Sense
  input wire single_channel_mode_o, // Single
  input wire [4:0] single_channel_mode_chan_o, // Channel
  input wire [2:0] pwm_o, // PWM
  input wire [23:0] cur_duty_o, // Duty
  input wire power_down_o, // Shutdown
  input wire [7:0] status_one_i, // Status one
  input wire status_two_any_i, // Status two
  input wire alert_pending_o, // Pending
  input wire alert_oe_o // Alert enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////
  lock_refuse_a:
  assert property (reg_wr_i && lock_i && reg_addr_i inside {8'h71, 8'h72} |=> wr_refused_o)
    else $error("locked offset write not refused");
  refuse_cause_a:
  assert property (wr_refused_o |-> $past(lock_i) && $past(reg_wr_i))
    else $error("refusal without locked write");
  local_valid_a:
  assert property (local_raw_valid_i |=> local_temp_valid_o)
    else $error("local result strobe missing");
  two_wire_a:
  assert property (two_wire_sense_o != 4'h0 |-> $past(low_freq_mode_i))
    else $error("two-wire sense outside low frequency");
  single_sel_a:
  assert property (single_channel_mode_o |-> !($past(chan_sel_i) inside {3'h0, 3'h3, 3'h4}))
    else $error("single mode on reserved code");
  single_channel_mode_map_a:
  assert property ($onehot0(single_channel_mode_chan_o) && ((single_channel_mode_chan_o != 5'h00) == single_channel_mode_o))
    else $error("channel select disagrees with mode");
  pwm_off_a:
  assert property (power_down_o |-> pwm_o == {3{$past(pwm_polarity_flip_i)}})
    else $error("pwm active in power down");
  duty_zero_a:
  assert property (power_down_o |-> cur_duty_o == 24'h000000)
    else $error("duty not zero in power down");
  alert_cause_a:
  assert property (alert_pending_o |-> ($past(status_one_i) & 8'h76) != 8'h00 || $past(status_two_any_i))
    else $error("alert without status");
  alert_pin_a:
  assert property (alert_oe_o == !alert_pending_o)
    else $error("alert pin disagrees with pending");
endmodule

//--- host_model.sv
// Host model: single-byte reads and writes on the register port.
// Assumes the slice answers on the cycle after each strobe.
module host_model (
  input wire clk_i, // Device clock
  input wire [7:0] rdata_i, // Read data
  output logic [7:0] addr_o, // Pointer
  output logic [7:0] data_o, // Write data
  output logic wr_o, // Write strobe
  output logic rd_o // Read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr_o, data_o, wr_o, rd_o} = '0;
  // Idle pointer and data inverted so stale values never pass
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    addr_o <= a;
    data_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    data_o <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    q = rdata_i;
  endtask
endmodule

//--- monitor_offset_config_mask_regs_tb.sv
// Self-checking bench for the offset, config and mask slice.
// Assumes the host model and the checker are compiled before it.
`include "monitor_regs_map.vh"
module monitor_offset_config_mask_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sense_thresh_i, sense_thresh_o, status_one_i;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, reg_hit_o, wr_refused_o, lock_i, low_freq_mode_i;
  logic pwm_polarity_flip_i, local_raw_valid_i, remote2_raw_valid_i, local_temp_valid_o;
  logic remote2_temp_valid_o, averaging_disable_o, attenuator_bypass_o, single_channel_mode_o;
  logic power_down_o, status_two_any_i, alert_pending_o, alert_out_o, alert_oe_o;
  logic [2:0] chan_sel_i, pwm_raw_i, pwm_o;
  logic [3:0] two_wire_sense_o;
  logic [4:0] single_channel_mode_chan_o, ex;
  logic [`TEMP_W-1:0] local_raw_i, remote2_raw_i, local_temp_o, remote2_temp_o, raw;
  logic [23:0] cur_duty_i, cur_duty_o;
  logic [7:0] d, m;
  logic [4:0] hot [8] = '{5'h00, 5'h01, 5'h02, 5'h00, 5'h00, 5'h04, 5'h08, 5'h10};
  int mdl [4] = '{0, 0, 0, 0};
  int fails = 0, checks = 0, e, seed = 32'hE3697756;
  always #25 clk_i = ~clk_i;
  host_model u_host (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .data_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  monitor_offset_config_mask_regs u_dut (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .reg_hit_o, .wr_refused_o, .lock_i, .low_freq_mode_i,
    .sense_thresh_i, .chan_sel_i, .pwm_polarity_flip_i, .local_raw_i, .local_raw_valid_i,
    .remote2_raw_i, .remote2_raw_valid_i, .local_temp_o, .local_temp_valid_o, .remote2_temp_o,
    .remote2_temp_valid_o, .two_wire_sense_o, .sense_thresh_o, .averaging_disable_o,
    .attenuator_bypass_o, .single_channel_mode_o, .single_channel_mode_chan_o, .pwm_raw_i, .pwm_o, .cur_duty_i,
    .cur_duty_o, .power_down_o, .status_one_i, .status_two_any_i, .alert_pending_o,
    .alert_out_o, .alert_oe_o);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wrm(input logic [7:0] a, dd);
    logic hit, lk;
    hit = a > 8'h70 && a < 8'h75;
    u_host.wr(a, dd);
    // Lock as the design saw it at the write edge
    lk = lock_i && a < 8'h73;
    if (hit && !lk)
      mdl[a - 8'h71] = dd;
    check(wr_refused_o, hit && lk);
    check(reg_hit_o, hit);
  endtask
  task automatic rdchk(input logic [7:0] a);
    logic [7:0] q;
    u_host.rd(a, q);
    check(q, (a > 8'h70 && a < 8'h75) ? mdl[a - 8'h71] : 0);
    check(reg_rvalid_o, 1);
    check(reg_hit_o, a > 8'h70 && a < 8'h75);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #400us;
    fails++;
    wrap_up();
  end
  initial
  begin
    {lock_i, low_freq_mode_i, sense_thresh_i, chan_sel_i, pwm_polarity_flip_i} = '0;
    {local_raw_i, local_raw_valid_i, remote2_raw_i, remote2_raw_valid_i} = '0;
    {pwm_raw_i, cur_duty_i, status_one_i, status_two_any_i} = '0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 5; i++)
      rdchk(8'(8'h71 + i));
    // Second half locked; includes an unmapped write
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      lock_i <= i[3];
      wrm(8'(8'h71 + i % 5), 8'($random(seed)));
      rdchk(8'(8'h71 + (i + 2) % 5));
    end
    @(posedge clk_i);
    lock_i <= 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      d = (i < 2) ? 8'h80 ^ {8{i[0]}} : 8'($random(seed));
      raw = (i < 2) ? {`TEMP_W{i[0]}} : `TEMP_W'($random(seed));
      wrm(i[1] ? 8'h72 : 8'h71, d);
      @(posedge clk_i);
      local_raw_i <= raw;
      remote2_raw_i <= raw;
      local_raw_valid_i <= !i[1];
      remote2_raw_valid_i <= i[1];
      @(posedge clk_i);
      {local_raw_valid_i, remote2_raw_valid_i} <= 2'b00;
      #1;
      e = int'(raw) + 2 * int'($signed(d));
      e = e < 0 ? 0 : (e > `TEMP_MAX ? `TEMP_MAX : e);
      check(i[1] ? remote2_temp_o : local_temp_o, e);
      check(i[1] ? remote2_temp_valid_o : local_temp_valid_o, 1);
    end
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($random(seed)) | (i < 8 ? 8'h40 : 8'h80);
      wrm(8'h73, d);
      @(posedge clk_i);
      {low_freq_mode_i, pwm_polarity_flip_i} <= 2'(i);
      sense_thresh_i <= ~d;
      chan_sel_i <= 3'(i);
      pwm_raw_i <= 3'($random(seed));
      cur_duty_i <= 24'($random(seed));
      @(posedge clk_i);
      #1;
      ex = d[6] ? hot[chan_sel_i] : 5'h00;
      check(two_wire_sense_o, low_freq_mode_i ? d[3:0] : 4'h0);
      check(sense_thresh_o, sense_thresh_i);
      check({averaging_disable_o, attenuator_bypass_o}, {d[4], d[5]});
      check(single_channel_mode_chan_o, ex);
      check(single_channel_mode_o, ex != 5'h00);
      check(power_down_o, d[7]);
      check(pwm_o, d[7] ? {3{pwm_polarity_flip_i}} : pwm_raw_i);
      check(cur_duty_o, d[7] ? 24'h000000 : cur_duty_i);
    end
    // First half masks all but the raised bit and bit 7; second half masks both
    for (int i = 0; i < 16; i++)
    begin
      d = 8'h01 << i[2:0];
      m = i[3] ? d | 8'h80 : ~d & 8'h7F;
      wrm(8'h74, m);
      @(posedge clk_i);
      status_one_i <= d;
      status_two_any_i <= (i[2:0] == 3'h0);
      @(posedge clk_i);
      #1;
      e = |(d & ~m & 8'h76) || (status_two_any_i && !m[7]);
      check(alert_pending_o, e);
      check({alert_oe_o, alert_out_o}, {e == 0, 1'b0});
    end
    // Reset again with every register holding a non-zero value
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    mdl = '{0, 0, 0, 0};
    for (int i = 0; i < 4; i++)
      rdchk(8'(8'h71 + i));
    check({power_down_o, alert_pending_o, single_channel_mode_o}, 3'h0);
    wrap_up();
  end
endmodule
bind monitor_offset_config_mask_regs monitor_regs_props u_props (.clk_i, .rstn_i, .reg_addr_i,
  .reg_wr_i, .wr_refused_o, .lock_i, .low_freq_mode_i, .chan_sel_i, .pwm_polarity_flip_i,
  .local_raw_valid_i, .local_temp_valid_o, .two_wire_sense_o, .single_channel_mode_o,
  .single_channel_mode_chan_o, .pwm_o, .cur_duty_o, .power_down_o, .status_one_i, .status_two_any_i,
  .alert_pending_o, .alert_oe_o);
